// [core/udee_consts.vh]
// constants shared by the usb device endpoint engine
`ifndef UDEE_CONSTS_VH
`define UDEE_CONSTS_VH
`define UDEE_PID_OUT 2'h0
`define UDEE_PID_IN 2'h1
`define UDEE_PID_SETUP 2'h2
`define UDEE_HS_ACK 2'h0
`define UDEE_HS_NAK 2'h1
`define UDEE_HS_STALL 2'h2
`define UDEE_TYPE_CTRL 2'h0
`define UDEE_TYPE_ISO 2'h1
`define UDEE_TYPE_BULK 2'h2
`define UDEE_TYPE_INTR 2'h3
`define UDEE_REC_BYTES 4'hA
`define UDEE_WB_WRITES 2'h3
`define UDEE_OFS_CTRL 4'h0
`define UDEE_OFS_STAT 4'h1
`define UDEE_OFS_PTR 4'h2
`define UDEE_OFS_DONE 4'h4
`define UDEE_OFS_MAX 4'h6
`define UDEE_OFS_TOT 4'h8
`define UDEE_CTRL_STALL 7
`define UDEE_CTRL_PP 6
`define UDEE_CTRL_MP 5
`define UDEE_STAT_ARMED 0
`define UDEE_MAX_PAYLOAD 10'h3FF
`define UDEE_FIFO_DEPTH 16
`define UDEE_FIFO_AW 4
`define UDEE_CLK_MHZ 40
`define UDEE_SUSPEND_US 3000
`define UDEE_SUSPEND_CYC (`UDEE_SUSPEND_US * `UDEE_CLK_MHZ)
`endif

// [core/udee_fifo.v]
// parameterised valid/ready fifo
`timescale 1ns/1ps
module udee_fifo #(
	parameter W = 8,
	parameter D = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_r != D[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_r];
	always @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // udee_fifo

// [core/udee_top.v]
// usb device endpoint engine: records and buffers in sram, completion queue, suspend
// Functional notes
// - full speed 12 or low speed 1.5 Mbit/s
// - sixteen endpoint addresses, one in, one out
// - thirty configurable endpoints plus control endpoint zero, in and out
// - per-address type: control, interrupt, bulk, isochronous
// - selectable payload size, up to 1023 bytes
// - records and buffers live in sram only
// - dma fetches record, moves data each transaction
// - ping-pong uses both endpoints in one direction
// - cpu owns one buffer, usb the other
// - multipacket moves large payloads without per-packet action
// - every completed transfer queued first-come first-served; multipacket queued on its last packet only
// - idle bus suspend requests microcontroller sleep
// - resume signalling wakes the microcontroller
// - usb suspend timing counted in system clock cycles, scaled by UDEE_CLK_MHZ
`timescale 1ns/1ps
`include "udee_consts.vh"
module udee_top #(
	parameter SUSPEND_CYCLES = `UDEE_SUSPEND_CYC
) (
	input wire CLK,
	input wire RESET,
	input wire SPEED_LOW,
	input wire LINE_DP,
	input wire LINE_DM,
	input wire [15:0] EP_BASE,
	input wire TOK_VALID,
	output wire TOK_READY,
	input wire [1:0] TOK_PID,
	input wire [3:0] TOK_EP,
	input wire RX_VALID,
	output wire RX_READY,
	input wire [7:0] RX_DATA,
	input wire RX_LAST,
	output reg TX_VALID,
	input wire TX_READY,
	output reg [7:0] TX_DATA,
	output reg TX_LAST,
	output reg TX_ZLP,
	output reg HS_VALID,
	output reg [1:0] HS_CODE,
	output reg MEM_REQ,
	output reg MEM_WE,
	output reg [15:0] MEM_ADDR,
	output reg [7:0] MEM_WDATA,
	input wire MEM_ACK,
	input wire [7:0] MEM_RDATA,
	output wire CPL_VALID,
	input wire CPL_POP,
	output wire [4:0] CPL_EP,
	output wire CPL_PENDING,
	output reg SLEEP_REQ,
	output reg WAKE_REQ
);
	localparam S_IDLE = 4'h0;
	localparam S_FETCH = 4'h1;
	localparam S_DECIDE = 4'h2;
	localparam S_RXW = 4'h3;
	localparam S_DRAIN = 4'h4;
	localparam S_TXR = 4'h5;
	localparam S_TXS = 4'h6;
	localparam S_WB = 4'h7;
	localparam S_CPL = 4'h8;
	// byte address of one field of an endpoint record
	function [15:0] rec_addr;
		input [15:0] base;
		input [4:0] idx;
		input [3:0] ofs;
		begin
			rec_addr = base + {7'h00, idx, 4'h0} + {12'h000, ofs};
		end
	endfunction
	function [9:0] min10;
		input [9:0] a;
		input [9:0] b;
		begin
			min10 = (a < b) ? a : b;
		end
	endfunction
	function [3:0] wb_ofs;
		input [1:0] k;
		begin
			if (k == 2'h0) begin
				wb_ofs = `UDEE_OFS_STAT;
			end else if (k == 2'h1) begin
				wb_ofs = `UDEE_OFS_DONE;
			end else begin
				wb_ofs = `UDEE_OFS_DONE + 4'h1;
			end
		end
	endfunction
	reg [3:0] state_r;
	reg [1:0] pid_r;
	reg [3:0] ep_r;
	reg [4:0] idx_r;
	reg [7:0] cfg_r [0:9];
	reg [3:0] cnt_r;
	reg [9:0] n_r;
	reg last_r;
	reg done_flag_r;
	reg [15:0] bank_r;
	reg dp_s1_r;
	reg dp_s2_r;
	reg dm_s1_r;
	reg dm_s2_r;
	reg [31:0] idle_r;
	wire dir_in = (pid_r == `UDEE_PID_IN);
	wire [7:0] ctrl = cfg_r[0];
	wire [1:0] ep_type = ctrl[1:0];
	wire armed = cfg_r[1][`UDEE_STAT_ARMED];
	wire [15:0] ptr = {cfg_r[3], cfg_r[2]};
	wire [9:0] done = {cfg_r[5][1:0], cfg_r[4]};
	wire [9:0] maxp = min10({cfg_r[7][1:0], cfg_r[6]}, `UDEE_MAX_PAYLOAD);
	wire [9:0] tot = {cfg_r[9][1:0], cfg_r[8]};
	wire mp = ctrl[`UDEE_CTRL_MP];
	wire [9:0] remain = (tot > done) ? tot - done : 10'h000;
	wire [9:0] pkt_len = min10(mp ? remain : tot, maxp);
	wire [9:0] data_ofs = (mp ? done : 10'h000) + n_r;
	wire [15:0] data_addr = ptr + {6'h00, data_ofs};
	wire [9:0] new_done = done + n_r;
	wire xfer_end = !mp || (n_r < maxp) || (new_done >= tot);
	wire setup_ctrl = (pid_r == `UDEE_PID_SETUP) && (ep_type == `UDEE_TYPE_CTRL);

	wire rxf_valid;
	wire rxf_ready;
	wire [8:0] rxf_data;
	wire cplf_ready;
	wire cpl_push = (state_r == S_CPL);

	udee_fifo #(.W(9), .D(`UDEE_FIFO_DEPTH), .AW(`UDEE_FIFO_AW)) u_rx_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(RX_VALID),
		.in_ready(RX_READY),
		.in_data({RX_LAST, RX_DATA}),
		.out_valid(rxf_valid),
		.out_ready(rxf_ready),
		.out_data(rxf_data)
	);

	udee_fifo #(.W(5), .D(`UDEE_FIFO_DEPTH), .AW(`UDEE_FIFO_AW)) u_cpl_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(cpl_push),
		.in_ready(cplf_ready),
		.in_data(idx_r),
		.out_valid(CPL_VALID),
		.out_ready(CPL_POP),
		.out_data(CPL_EP)
	);

	assign CPL_PENDING = CPL_VALID;
	assign TOK_READY = (state_r == S_IDLE);
	assign rxf_ready = ((state_r == S_RXW) && !MEM_REQ) || (state_r == S_DRAIN);

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_r <= S_IDLE;
			pid_r <= 2'h0;
			ep_r <= 4'h0;
			idx_r <= 5'h00;
			cnt_r <= 4'h0;
			n_r <= 10'h000;
			last_r <= 1'b0;
			done_flag_r <= 1'b0;
			bank_r <= 16'h0000;
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			TX_LAST <= 1'b0;
			TX_ZLP <= 1'b0;
			HS_VALID <= 1'b0;
			HS_CODE <= 2'h0;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 16'h0000;
			MEM_WDATA <= 8'h00;
			cfg_r[0] <= 8'h00;
			cfg_r[1] <= 8'h00;
			cfg_r[2] <= 8'h00;
			cfg_r[3] <= 8'h00;
			cfg_r[4] <= 8'h00;
			cfg_r[5] <= 8'h00;
			cfg_r[6] <= 8'h00;
			cfg_r[7] <= 8'h00;
			cfg_r[8] <= 8'h00;
			cfg_r[9] <= 8'h00;
		end else begin
			HS_VALID <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (TOK_VALID) begin
						pid_r <= TOK_PID;
						ep_r <= TOK_EP;
						// ping-pong: the bank picks the record, both in one direction
						if (bank_r[TOK_EP] && (TOK_EP != 4'h0)) begin
							idx_r <= {TOK_EP, TOK_PID != `UDEE_PID_IN};
						end else begin
							idx_r <= {TOK_EP, TOK_PID == `UDEE_PID_IN};
						end
						cnt_r <= 4'h0;
						n_r <= 10'h000;
						state_r <= S_FETCH;
					end
				end
				S_FETCH: begin
					// record fetched from sram, only the ping-pong bank bits kept locally between tokens
					if (MEM_REQ && MEM_ACK) begin
						MEM_REQ <= 1'b0;
						cfg_r[cnt_r] <= MEM_RDATA;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == `UDEE_REC_BYTES - 4'h1) begin
							state_r <= S_DECIDE;
						end
					end else if (!MEM_REQ) begin
						MEM_REQ <= 1'b1;
						MEM_WE <= 1'b0;
						MEM_ADDR <= rec_addr(EP_BASE, idx_r, cnt_r);
					end
				end
				S_DECIDE: begin
					if (setup_ctrl) begin
						state_r <= S_RXW;
					end else if (ctrl[`UDEE_CTRL_STALL] || !armed) begin
						HS_VALID <= (ep_type != `UDEE_TYPE_ISO);
						HS_CODE <= ctrl[`UDEE_CTRL_STALL] ? `UDEE_HS_STALL : `UDEE_HS_NAK;
						state_r <= dir_in ? S_IDLE : S_DRAIN;
					end else if (!dir_in) begin
						state_r <= S_RXW;
					end else if (pkt_len == 10'h000) begin
						TX_VALID <= 1'b1;
						TX_LAST <= 1'b1;
						TX_ZLP <= 1'b1;
						state_r <= S_TXS;
					end else begin
						state_r <= S_TXR;
					end
				end
				S_RXW: begin
					if (MEM_REQ) begin
						if (MEM_ACK) begin
							MEM_REQ <= 1'b0;
							n_r <= n_r + 10'h001;
							if (last_r) begin
								state_r <= S_WB;
							end
						end
					end else if (rxf_valid) begin
						last_r <= rxf_data[8];
						// bytes past the payload limit are dropped
						if (n_r < maxp) begin
							MEM_REQ <= 1'b1;
							MEM_WE <= 1'b1;
							MEM_ADDR <= data_addr;
							MEM_WDATA <= rxf_data[7:0];
						end else if (rxf_data[8]) begin
							state_r <= S_WB;
						end
					end
					cnt_r <= 4'h0;
				end
				S_DRAIN: begin
					if (rxf_valid && rxf_data[8]) begin
						state_r <= S_IDLE;
					end
				end
				S_TXR: begin
					if (MEM_REQ && MEM_ACK) begin
						MEM_REQ <= 1'b0;
						TX_VALID <= 1'b1;
						TX_DATA <= MEM_RDATA;
						TX_LAST <= (n_r + 10'h001 == pkt_len);
						TX_ZLP <= 1'b0;
						state_r <= S_TXS;
					end else if (!MEM_REQ) begin
						MEM_REQ <= 1'b1;
						MEM_WE <= 1'b0;
						MEM_ADDR <= data_addr;
					end
				end
				S_TXS: begin
					if (TX_READY) begin
						TX_VALID <= 1'b0;
						if (!TX_ZLP) begin
							n_r <= n_r + 10'h001;
						end
						state_r <= TX_LAST ? S_WB : S_TXR;
					end
					cnt_r <= 4'h0;
				end
				S_WB: begin
					if (cnt_r == 4'h0 && !MEM_REQ) begin
						// status and progress are returned to the record
						done_flag_r <= xfer_end || setup_ctrl;
						if (xfer_end || setup_ctrl) begin
							cfg_r[1] <= cfg_r[1] & ~(8'h01 << `UDEE_STAT_ARMED);
						end
						cfg_r[4] <= new_done[7:0];
						cfg_r[5] <= {6'h00, new_done[9:8]};
						HS_VALID <= !dir_in && (ep_type != `UDEE_TYPE_ISO);
						HS_CODE <= `UDEE_HS_ACK;
						cnt_r <= 4'h1;
					end else if (MEM_REQ && MEM_ACK) begin
						MEM_REQ <= 1'b0;
						if (cnt_r == {2'h0, `UDEE_WB_WRITES}) begin
							// hand the used buffer back to the cpu side
							if (ctrl[`UDEE_CTRL_PP] && (ep_r != 4'h0)) begin
								bank_r[ep_r] <= ~bank_r[ep_r];
							end
							state_r <= done_flag_r ? S_CPL : S_IDLE;
						end else begin
							cnt_r <= cnt_r + 4'h1;
						end
					end else if (!MEM_REQ) begin
						MEM_REQ <= 1'b1;
						MEM_WE <= 1'b1;
						MEM_ADDR <= rec_addr(EP_BASE, idx_r, wb_ofs(cnt_r[1:0] - 2'h1));
						MEM_WDATA <= cfg_r[wb_ofs(cnt_r[1:0] - 2'h1)];
					end
				end
				S_CPL: begin
					if (cplf_ready) begin
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// line state idle detection; idle time counted in CLK cycles up to SUSPEND_CYCLES
	wire line_j = SPEED_LOW ? (!dp_s2_r && dm_s2_r) : (dp_s2_r && !dm_s2_r);
	wire line_k = SPEED_LOW ? (dp_s2_r && !dm_s2_r) : (!dp_s2_r && dm_s2_r);

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			dp_s1_r <= 1'b0;
			dp_s2_r <= 1'b0;
			dm_s1_r <= 1'b0;
			dm_s2_r <= 1'b0;
			idle_r <= 32'h00000000;
			SLEEP_REQ <= 1'b0;
			WAKE_REQ <= 1'b0;
		end else begin
			dp_s1_r <= LINE_DP;
			dp_s2_r <= dp_s1_r;
			dm_s1_r <= LINE_DM;
			dm_s2_r <= dm_s1_r;
			WAKE_REQ <= 1'b0;
			if (SLEEP_REQ) begin
				idle_r <= 32'h00000000;
				if (line_k) begin
					SLEEP_REQ <= 1'b0;
					WAKE_REQ <= 1'b1;
				end
			end else if (!line_j) begin
				idle_r <= 32'h00000000;
			end else if (idle_r >= SUSPEND_CYCLES - 1) begin
				SLEEP_REQ <= 1'b1;
			end else begin
				idle_r <= idle_r + 32'h00000001;
			end
		end
	end
endmodule // udee_top

// [tb/udee_sram_model.sv]
// sram model serving the engine's dma requests
`timescale 1ns/1ps
module udee_sram_model (
	input wire clk,
	input wire req,
	input wire we,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	output logic ack,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:1023];
	initial begin
		ack = 1'b0;
		rdata = 8'h00;
	end
	always @(posedge clk) begin
		rdata <= ~rdata;
		ack <= req && !ack;
		if (req && !ack) begin
			if (we)
				mem[addr[9:0]] <= wdata;
			else
				rdata <= mem[addr[9:0]];
		end
	end
endmodule // udee_sram_model

// [tb/udee_top_asserts.sv]
// concurrent checks on the engine's ports
`timescale 1ns/1ps
module udee_top_asserts #(
	parameter SUSPEND_CYCLES = 20
) (
	input wire CLK,
	input wire RESET,
	input wire SPEED_LOW,
	input wire LINE_DP,
	input wire LINE_DM,
	input wire TOK_VALID,
	input wire TOK_READY,
	input wire TX_VALID,
	input wire TX_READY,
	input wire [7:0] TX_DATA,
	input wire TX_LAST,
	input wire HS_VALID,
	input wire MEM_REQ,
	input wire MEM_WE,
	input wire [15:0] MEM_ADDR,
	input wire [7:0] MEM_WDATA,
	input wire MEM_ACK,
	input wire CPL_VALID,
	input wire CPL_POP,
	input wire [4:0] CPL_EP,
	input wire CPL_PENDING,
	input wire SLEEP_REQ,
	input wire WAKE_REQ
);
	wire j_line = SPEED_LOW ? (!LINE_DP && LINE_DM) : (LINE_DP && !LINE_DM);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable({MEM_WE, MEM_ADDR, MEM_WDATA}))
		else $error("memory request changed before ack");
	AST_TOK_FETCH: assert property (TOK_VALID && TOK_READY |=> !TOK_READY && !MEM_REQ
		##1 MEM_REQ && !MEM_WE && MEM_ADDR[3:0] == 4'h0)
		else $error("token not followed by record fetch");
	AST_IDLE_NO_MEM: assert property (TOK_READY |-> !MEM_REQ)
		else $error("memory access while idle");
	AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable({TX_DATA, TX_LAST}))
		else $error("tx beat changed before ready");
	AST_CPL_HOLD: assert property (CPL_VALID && !CPL_POP |=> CPL_VALID && $stable(CPL_EP))
		else $error("completion head lost without pop");
	AST_CPL_PEND: assert property (CPL_PENDING == CPL_VALID)
		else $error("pending flag differs from queue state");
	AST_SLEEP_J: assert property ($rose(SLEEP_REQ) |-> $past(j_line, 4) && $past(j_line, 8))
		else $error("sleep without idle bus");
	AST_WAKE: assert property (WAKE_REQ |-> !SLEEP_REQ && $past(SLEEP_REQ))
		else $error("wake without prior sleep");
	AST_WAKE_PULSE: assert property (WAKE_REQ |=> !WAKE_REQ)
		else $error("wake longer than one cycle");
	AST_HS_PULSE: assert property (HS_VALID |=> !HS_VALID)
		else $error("handshake longer than one cycle");
endmodule // udee_top_asserts
bind udee_top udee_top_asserts #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) i_udee_top_asserts (
	.CLK(CLK), .RESET(RESET), .SPEED_LOW(SPEED_LOW), .LINE_DP(LINE_DP), .LINE_DM(LINE_DM),
	.TOK_VALID(TOK_VALID), .TOK_READY(TOK_READY), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
	.TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .HS_VALID(HS_VALID), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .CPL_VALID(CPL_VALID), .CPL_POP(CPL_POP),
	.CPL_EP(CPL_EP), .CPL_PENDING(CPL_PENDING), .SLEEP_REQ(SLEEP_REQ), .WAKE_REQ(WAKE_REQ)
);

// [tb/tb_usb_device_endpoint_engine.sv]
// self-checking bench for the endpoint engine
`timescale 1ns/1ps
`include "udee_consts.vh"
module tb_usb_device_endpoint_engine;
	logic CLK = 0, RESET = 1, LINE_DP = 0, LINE_DM = 0, TOK_VALID = 0, RX_VALID = 0, RX_LAST = 0;
	logic TX_READY = 0, CPL_POP = 0, SPEED_LOW = 0;
	logic [1:0] TOK_PID = 0;
	logic [3:0] TOK_EP = 0;
	logic [7:0] RX_DATA = 0;
	wire TOK_READY, RX_READY, TX_VALID, TX_LAST, TX_ZLP, HS_VALID, MEM_REQ, MEM_WE, MEM_ACK;
	wire CPL_VALID, CPL_PENDING, SLEEP_REQ, WAKE_REQ;
	wire [7:0] TX_DATA, MEM_WDATA, MEM_RDATA;
	wire [1:0] HS_CODE;
	wire [15:0] MEM_ADDR;
	wire [4:0] CPL_EP;
	int errors = 0, comparisons = 0, cycles = 0;
	always #12.5 CLK = ~CLK;
	udee_top #(.SUSPEND_CYCLES(20)) i_udee_top (.CLK(CLK), .RESET(RESET), .SPEED_LOW(SPEED_LOW),
		.LINE_DP(LINE_DP), .LINE_DM(LINE_DM), .EP_BASE(16'h0000), .TOK_VALID(TOK_VALID),
		.TOK_READY(TOK_READY), .TOK_PID(TOK_PID), .TOK_EP(TOK_EP), .RX_VALID(RX_VALID),
		.RX_READY(RX_READY), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_ZLP(TX_ZLP),
		.HS_VALID(HS_VALID), .HS_CODE(HS_CODE), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.CPL_VALID(CPL_VALID), .CPL_POP(CPL_POP), .CPL_EP(CPL_EP), .CPL_PENDING(CPL_PENDING),
		.SLEEP_REQ(SLEEP_REQ), .WAKE_REQ(WAKE_REQ));
	udee_sram_model i_udee_sram_model (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
		.wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tally_and_finish;
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish;
		end
	end
	task rec(input int a, input logic [7:0] ctl, st, input logic [9:0] mx, tot, input logic [15:0] p);
		i_udee_sram_model.mem[a] = ctl;
		i_udee_sram_model.mem[a + 1] = st;
		i_udee_sram_model.mem[a + 2] = p[7:0];
		i_udee_sram_model.mem[a + 3] = p[15:8];
		i_udee_sram_model.mem[a + 4] = 8'h00;
		i_udee_sram_model.mem[a + 5] = 8'h00;
		i_udee_sram_model.mem[a + 6] = mx[7:0];
		i_udee_sram_model.mem[a + 7] = {6'h00, mx[9:8]};
		i_udee_sram_model.mem[a + 8] = tot[7:0];
		i_udee_sram_model.mem[a + 9] = {6'h00, tot[9:8]};
	endtask
	task tok(input logic [1:0] pid, input logic [3:0] ep);
		int t;
		TOK_PID = pid;
		TOK_EP = ep;
		TOK_VALID = 1;
		for (t = 0; t < 500 && TOK_READY !== 1'b1; t++) @(negedge CLK);
		@(negedge CLK);
		TOK_VALID = 0;
	endtask
	task rx(input logic [7:0] d, input logic l);
		int t;
		RX_DATA = d;
		RX_LAST = l;
		for (t = 0; t < 500 && RX_READY !== 1'b1; t++) @(negedge CLK);
		@(negedge CLK);
	endtask
	task idle;
		int t;
		for (t = 0; t < 500 && TOK_READY !== 1'b1; t++) @(negedge CLK);
	endtask
	task hs(input logic [1:0] c);
		int t;
		for (t = 0; t < 500 && HS_VALID !== 1'b1; t++) @(negedge CLK);
		chk("handshake", {HS_VALID, HS_CODE}, {1'b1, c});
	endtask
	task take(input int n, input logic [7:0] b0);
		int t, k;
		logic last;
		k = 0;
		last = 0;
		for (t = 0; t < 500 && !last; t++) begin
			@(negedge CLK);
			TX_READY = t[0];
			if (TX_VALID === 1'b1 && TX_READY) begin
				chk("tx_data", {TX_ZLP, TX_DATA}, b0 + k);
				k++;
				last = TX_LAST;
			end
		end
		chk("tx_count", k, n);
		@(negedge CLK);
		TX_READY = 0;
	endtask
	task t_reset;
		chk("reset_out", {TOK_READY, RX_READY, SLEEP_REQ, CPL_VALID, MEM_REQ}, 16'h0018);
	endtask
	task t_refuse;
		int i;
		rec(16'h60, 8'h82, 8'h01, 10'h008, 10'h008, 16'h0200);
		rec(16'h80, 8'h02, 8'h00, 10'h008, 10'h008, 16'h0200);
		for (i = 0; i < 2; i++) begin
			RX_VALID = 1;
			rx(8'h55, 1);
			RX_VALID = 0;
			tok(`UDEE_PID_OUT, 4'h3 + i);
			hs(i ? `UDEE_HS_NAK : `UDEE_HS_STALL);
			idle;
		end
	endtask
	task t_out;
		int i;
		rec(16'h20, 8'h02, 8'h01, 10'h008, 10'h008, 16'h0200);
		i_udee_sram_model.mem[16'h208] = 8'hEE;
		RX_VALID = 1;
		for (i = 0; i < 16; i++) rx(8'h10 + i, i == 15);
		chk("rx_full", RX_READY, 16'h0000);
		RX_VALID = 0;
		tok(`UDEE_PID_OUT, 4'h1);
		hs(`UDEE_HS_ACK);
		idle;
		for (i = 0; i < 8; i++) chk("out_byte", i_udee_sram_model.mem[16'h200 + i], 8'h10 + i);
		chk("out_cap", i_udee_sram_model.mem[16'h208], 16'h00EE);
		chk("out_done", i_udee_sram_model.mem[16'h24], 16'h0008);
		chk("out_armed", i_udee_sram_model.mem[16'h21], 16'h0000);
	endtask
	task t_in;
		rec(16'h50, 8'h23, 8'h01, 10'h002, 10'h003, 16'h0300);
		i_udee_sram_model.mem[16'h300] = 8'hA0;
		i_udee_sram_model.mem[16'h301] = 8'hA1;
		i_udee_sram_model.mem[16'h302] = 8'hA2;
		tok(`UDEE_PID_IN, 4'h2);
		take(2, 8'hA0);
		idle;
		chk("in_done1", {i_udee_sram_model.mem[16'h54], i_udee_sram_model.mem[16'h51]}, 16'h0201);
		tok(`UDEE_PID_IN, 4'h2);
		take(1, 8'hA2);
		idle;
		chk("in_done2", {i_udee_sram_model.mem[16'h54], i_udee_sram_model.mem[16'h51]}, 16'h0300);
	endtask
	task t_cpl;
		chk("cpl_first", CPL_EP, 16'h0002);
		CPL_POP = 1;
		@(negedge CLK);
		chk("cpl_second", {CPL_PENDING, CPL_EP}, 16'h0025);
		@(negedge CLK);
		CPL_POP = 0;
		chk("cpl_empty", CPL_VALID, 16'h0000);
	endtask
	task t_pp_setup;
		int i;
		rec(16'hA0, 8'h42, 8'h01, 10'h004, 10'h004, 16'h0100);
		rec(16'hB0, 8'h42, 8'h01, 10'h004, 10'h004, 16'h0140);
		rec(16'h00, 8'h80, 8'h00, 10'h008, 10'h008, 16'h0180);
		for (i = 0; i < 3; i++) begin
			RX_VALID = 1;
			rx(8'h30 + i, 1);
			RX_VALID = 0;
			tok(i == 2 ? `UDEE_PID_SETUP : `UDEE_PID_OUT, i == 2 ? 4'h0 : 4'h5);
			hs(`UDEE_HS_ACK);
			idle;
		end
		chk("pp_bank0", i_udee_sram_model.mem[16'h100], 16'h0030);
		chk("pp_bank1", i_udee_sram_model.mem[16'h140], 16'h0031);
		chk("setup_data", i_udee_sram_model.mem[16'h180], 16'h0032);
		chk("setup_done", i_udee_sram_model.mem[16'h04], 16'h0001);
	endtask
	task t_zlp_iso;
		int t;
		logic seen;
		rec(16'hD0, 8'h02, 8'h01, 10'h008, 10'h000, 16'h01C0);
		rec(16'hF0, 8'h01, 8'h00, 10'h008, 10'h008, 16'h01C0);
		tok(`UDEE_PID_IN, 4'h6);
		for (t = 0; t < 500 && TX_VALID !== 1'b1; t++) @(negedge CLK);
		chk("zlp_beat", {TX_VALID, TX_LAST, TX_ZLP}, 16'h0007);
		TX_READY = 1;
		@(negedge CLK);
		TX_READY = 0;
		chk("zlp_taken", TX_VALID, 16'h0000);
		idle;
		seen = 0;
		tok(`UDEE_PID_IN, 4'h7);
		for (t = 0; t < 60; t++) begin
			seen = seen | (HS_VALID === 1'b1);
			@(negedge CLK);
		end
		chk("iso_no_hs", {seen, TOK_READY}, 16'h0001);
	endtask
	task t_cpl_order;
		int i;
		logic [7:0] want [0:3];
		want = '{8'h2A, 8'h2B, 8'h20, 8'h2D};
		for (i = 0; i < 4; i++) begin
			chk("cpl_order", {CPL_PENDING, CPL_EP}, want[i]);
			CPL_POP = 1;
			@(negedge CLK);
		end
		CPL_POP = 0;
		chk("cpl_drained", CPL_VALID, 16'h0000);
	endtask
	task t_sleep;
		int t, s;
		for (s = 0; s < 2; s++) begin
			SPEED_LOW = s[0];
			LINE_DP = !s[0];
			LINE_DM = s[0];
			repeat (30) @(negedge CLK);
			chk("sleep", SLEEP_REQ, 16'h0001);
			LINE_DP = s[0];
			LINE_DM = !s[0];
			for (t = 0; t < 10 && WAKE_REQ !== 1'b1; t++) @(negedge CLK);
			chk("wake", {WAKE_REQ, SLEEP_REQ}, 16'h0002);
			@(negedge CLK);
		end
	endtask
	initial begin
		repeat (12) @(negedge CLK);
		RESET = 0;
		t_reset;
		t_refuse;
		t_out;
		t_in;
		t_cpl;
		t_pp_setup;
		t_zlp_iso;
		t_cpl_order;
		t_sleep;
		tally_and_finish;
	end
endmodule // tb_usb_device_endpoint_engine
